// [rtl/dcb_consts.svh]
// Timing-free constants for the dual controller bus interface.
// Assumes inclusion by bare name from rtl/ files.
`ifndef DCB_CONSTS_SVH
`define DCB_CONSTS_SVH
`define DCB_HOST_MEM_BYTES   4096
`define DCB_DEV_MEM_BYTES    2462
`define DCB_DEV_AREAS        16
`define DCB_DEV_PROG_EPS     14
`define DCB_EP_MIN_BYTES     16
`define DCB_EP_MAX_BYTES     1023
`define DCB_MAX_BLOCKS       32
`define DCB_HDR_BYTES        8
`define DCB_DWORD_BYTES      4
`define DCB_PIN_IDLE         10'h26a
`endif

// [rtl/dcb_pkg.sv]
// Types for the dual controller bus interface.
// Assumes nothing of its surroundings.
package dcb_pkg;
   typedef enum logic [2:0] {
      DCB_IDLE    = 3'b000,
      DCB_PIO_HST = 3'b001,
      DCB_PIO_DEV = 3'b010,
      DCB_DMA_HST = 3'b011,
      DCB_DMA_DEV = 3'b100,
      DCB_OFF     = 3'b101
   } dcb_path_e;
endpackage : dcb_pkg

// [rtl/dcb_host_map.sv]
// Host buffer map: region starts, block counts and iso next-header address.
// Assumes size settings are held stable by software while traffic runs.
`timescale 1ns/1ps
`include "dcb_consts.svh"
module dcb_host_map #(
   parameter int AW = 13
) (
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   input  wire logic [AW-1:0] i_iso_size,
   input  wire logic [AW-1:0] i_int_size,
   input  wire logic [AW-1:0] i_async_size,
   input  wire logic [AW-1:0] i_int_blk,
   input  wire logic [AW-1:0] i_async_blk,
   input  wire logic [AW-1:0] i_iso_hdr,
   input  wire logic [AW-1:0] i_iso_total,
   output logic      [AW-1:0] o_iso_b_start,
   output logic      [AW-1:0] o_int_start,
   output logic      [AW-1:0] o_async_start,
   output logic      [AW-1:0] o_unused_start,
   output logic      [5:0]    o_int_blocks,
   output logic      [5:0]    o_async_blocks,
   output logic      [AW-1:0] o_iso_next_hdr
);
   logic [AW-1:0] pad_d;

   function automatic logic [5:0] blocks(input logic [AW-1:0] size, input logic [AW-1:0] blk);
      logic [AW-1:0] n;
      n = (blk == '0) ? '0 : size / (blk + AW'(`DCB_HDR_BYTES));
      blocks = (n > AW'(`DCB_MAX_BLOCKS)) ? 6'(`DCB_MAX_BLOCKS) : n[5:0];
   endfunction : blocks

   always_comb begin
      pad_d = (i_iso_total + AW'(`DCB_DWORD_BYTES - 1)) & ~AW'(`DCB_DWORD_BYTES - 1);
   end

   // Regions packed from zero in order iso A, iso B, interrupt, async.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_iso_b_start  <= '0;
         o_int_start    <= '0;
         o_async_start  <= '0;
         o_unused_start <= '0;
      end else begin
         o_iso_b_start  <= i_iso_size;
         o_int_start    <= AW'(i_iso_size + i_iso_size);
         o_async_start  <= AW'(i_iso_size + i_iso_size + i_int_size);
         o_unused_start <= AW'(i_iso_size + i_iso_size + i_int_size + i_async_size);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_int_blocks   <= '0;
         o_async_blocks <= '0;
      end else begin
         o_int_blocks   <= blocks(i_int_size, i_int_blk);
         o_async_blocks <= blocks(i_async_size, i_async_blk);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_iso_next_hdr <= '0;
      end else begin
         o_iso_next_hdr <= AW'(i_iso_hdr + AW'(`DCB_HDR_BYTES) + pad_d);
      end
   end

   a_iso_pad: assert property (@(posedge i_clk) disable iff (i_rst)
      1'b1 |=> o_iso_next_hdr[1:0] == $past(i_iso_hdr[1:0]))
      else $error("iso header not dword aligned");
   a_blk_cap: assert property (@(posedge i_clk) disable iff (i_rst)
      o_int_blocks <= 6'd32 && o_async_blocks <= 6'd32)
      else $error("block count above cap");
   a_region_order: assert property (@(posedge i_clk) disable iff (i_rst)
      ##1 o_async_start == AW'(o_int_start + $past(i_int_size)))
      else $error("async start wrong");
endmodule : dcb_host_map

// [rtl/dcb_bus_if.sv]
// Bus interface top: routes PIO and DMA accesses to host or device controller paths.
// Assumes synchronous-to-i_clk controller sides; host pins pass three-stage synchronisers.
// Operation
// - Controller-select line routes each PIO access to host or device path.
// - Select low picks host PIO bus, high picks device PIO bus.
// - Register access is command phase then data phase, chosen by phase line.
// - Registers reachable by PIO only; buffers by PIO and DMA.
// - With chip select low, select wins and DMA acks are ignored.
// - With chip select high, DMA signals serve; select line ignored.
// - Ack without matching request is ignored.
// - Both requests and both acks active switches interface off.
// - Host DMA on ack1/req1/no req2, device mirrored, nothing if both requests.
// - In DMA cases the ack level alone enables the data bus; here the request and rd_n low are also needed.
// - Data bus floats whenever no access is in progress.
// - Host buffer is 4096 bytes in four regions.
// - Host regions placed from zero in order, starts are running sums.
// - Hardware sizes regions from settings; software keeps even, equal iso sizes.
// - Interrupt and async buffers split into equal blocks, at most 32.
// - Iso next header is header plus payload rounded to four bytes.
// - Device buffer is 2462 bytes in sixteen endpoint areas.
// - All sixteen endpoints configured before allocation, sizes 16 to 1023; here only endpoints 2 to 15 are flagged below 16.
// - Device buffer has no direct addressing, only endpoint buffer accesses.
// - Channel 1 carries host DMA, channel 2 device, ended by end of transfer.
`timescale 1ns/1ps
`include "dcb_consts.svh"
module dcb_bus_if #(
   parameter int DW = 16,
   parameter int AW = 13
) (
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   input  wire logic          i_chip_sel_n,
   input  wire logic          i_controller_select_line,
   input  wire logic          i_phase_select_line,
   input  wire logic          i_rd_n,
   input  wire logic          i_wr_n,
   input  wire logic          i_host_dma_request,
   input  wire logic          i_host_dma_ack_n,
   input  wire logic          i_dev_dma_request,
   input  wire logic          i_dev_dma_ack_n,
   input  wire logic [DW-1:0] i_data,
   output logic      [DW-1:0] o_data,
   output logic               o_data_oe,
   input  wire logic [DW-1:0] i_host_rdata,
   input  wire logic [DW-1:0] i_dev_rdata,
   output logic      [DW-1:0] o_wdata,
   output logic               o_host_cmd_wr,
   output logic               o_host_data_wr,
   output logic               o_host_data_rd,
   output logic               o_host_buf_dma,
   output logic               o_dev_cmd_wr,
   output logic               o_dev_data_wr,
   output logic               o_dev_data_rd,
   output logic               o_dev_buf_dma,
   output logic               o_dma_write,
   input  wire logic          i_host_end_of_transfer,
   input  wire logic          i_dev_end_of_transfer,
   output logic               o_host_dma_done,
   output logic               o_dev_dma_done,
   output logic               o_bus_off,
   output logic [2:0]         o_path,
   input  wire logic [AW-1:0] i_iso_buffer_size_setting,
   input  wire logic [AW-1:0] i_interrupt_buffer_size_setting,
   input  wire logic [AW-1:0] i_async_buffer_size_setting,
   input  wire logic [AW-1:0] i_interrupt_block_size_setting,
   input  wire logic [AW-1:0] i_async_block_size_setting,
   input  wire logic [AW-1:0] i_iso_hdr_addr,
   input  wire logic [AW-1:0] i_iso_total_size,
   output logic      [AW-1:0] o_iso_b_start,
   output logic      [AW-1:0] o_int_start,
   output logic      [AW-1:0] o_async_start,
   output logic      [AW-1:0] o_unused_start,
   output logic      [5:0]    o_int_blocks,
   output logic      [5:0]    o_async_blocks,
   output logic      [AW-1:0] o_iso_next_hdr,
   output logic               o_host_map_overflow,
   input  wire logic          i_ep_cfg_wr,
   input  wire logic [3:0]    i_ep_cfg_index,
   input  wire logic          i_ep_cfg_dbl,
   input  wire logic [9:0]    i_ep_cfg_size,
   output logic               o_ep_alloc_done,
   output logic               o_ep_cfg_err
);
   localparam int NSYNC = 10;
   localparam int NEP   = `DCB_DEV_AREAS;

   // Three-stage synchronisers; a change counts when stages two and three agree.
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   logic [NSYNC-1:0] s3_q;
   logic [NSYNC-1:0] pin_q;
   logic [NSYNC-1:0] raw;

   assign raw = {i_chip_sel_n, i_controller_select_line, i_phase_select_line, i_rd_n, i_wr_n,
                 i_host_dma_request, i_host_dma_ack_n, i_dev_dma_request, i_dev_dma_ack_n,
                 1'b0};

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= `DCB_PIN_IDLE;
         s2_q <= `DCB_PIN_IDLE;
         s3_q <= `DCB_PIN_IDLE;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_pin
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               pin_q[g] <= 1'((`DCB_PIN_IDLE) >> g);
            end else if (s2_q[g] == s3_q[g]) begin
               pin_q[g] <= s3_q[g];
            end
         end
      end
   endgenerate

   logic cs_n;
   logic csel;
   logic phase;
   logic rd_n;
   logic wr_n;
   logic req1;
   logic ack1_n;
   logic req2;
   logic ack2_n;
   assign cs_n   = pin_q[9];
   assign csel   = pin_q[8];
   assign phase  = pin_q[7];
   assign rd_n   = pin_q[6];
   assign wr_n   = pin_q[5];
   assign req1   = pin_q[4];
   assign ack1_n = pin_q[3];
   assign req2   = pin_q[2];
   assign ack2_n = pin_q[1];

   // Arbitration of the bus owner.
   dcb_pkg::dcb_path_e path_d;
   always_comb begin
      path_d = dcb_pkg::DCB_IDLE;
      if (!cs_n) begin
         path_d = csel ? dcb_pkg::DCB_PIO_DEV : dcb_pkg::DCB_PIO_HST;
      end else if (req1 && req2 && !ack1_n && !ack2_n) begin
         path_d = dcb_pkg::DCB_OFF;
      end else if (req1 && req2) begin
         path_d = dcb_pkg::DCB_IDLE;
      end else if (req1 && !ack1_n) begin
         path_d = dcb_pkg::DCB_DMA_HST;
      end else if (req2 && !ack2_n) begin
         path_d = dcb_pkg::DCB_DMA_DEV;
      end
   end

   dcb_pkg::dcb_path_e path_q;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         path_q <= dcb_pkg::DCB_IDLE;
      end else begin
         path_q <= path_d;
      end
   end
   assign o_path   = path_q;
   assign o_bus_off = (path_q == dcb_pkg::DCB_OFF);

   // Strobes: each PIO or DMA access is a single pulse on the falling strobe edge.
   logic rd_prev_q;
   logic wr_prev_q;
   logic rd_fall;
   logic wr_fall;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_prev_q <= 1'b1;
         wr_prev_q <= 1'b1;
      end else begin
         rd_prev_q <= rd_n;
         wr_prev_q <= wr_n;
      end
   end
   assign rd_fall = rd_prev_q && !rd_n;
   assign wr_fall = wr_prev_q && !wr_n;

   logic pio_h;
   logic pio_d;
   logic dma_h;
   logic dma_d;
   assign pio_h = (path_d == dcb_pkg::DCB_PIO_HST);
   assign pio_d = (path_d == dcb_pkg::DCB_PIO_DEV);
   assign dma_h = (path_d == dcb_pkg::DCB_DMA_HST);
   assign dma_d = (path_d == dcb_pkg::DCB_DMA_DEV);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_host_cmd_wr  <= 1'b0;
         o_host_data_wr <= 1'b0;
         o_host_data_rd <= 1'b0;
         o_dev_cmd_wr   <= 1'b0;
         o_dev_data_wr  <= 1'b0;
         o_dev_data_rd  <= 1'b0;
         o_host_buf_dma <= 1'b0;
         o_dev_buf_dma  <= 1'b0;
         o_dma_write    <= 1'b0;
      end else begin
         o_host_cmd_wr  <= pio_h && phase && wr_fall;
         o_host_data_wr <= pio_h && !phase && wr_fall;
         o_host_data_rd <= pio_h && !phase && rd_fall;
         o_dev_cmd_wr   <= pio_d && phase && wr_fall;
         o_dev_data_wr  <= pio_d && !phase && wr_fall;
         o_dev_data_rd  <= pio_d && !phase && rd_fall;
         // DMA reaches buffers only, never the command port.
         o_host_buf_dma <= dma_h && (rd_fall || wr_fall);
         o_dev_buf_dma  <= dma_d && (rd_fall || wr_fall);
         o_dma_write    <= (dma_h || dma_d) && wr_fall;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wdata <= '0;
      end else if (wr_fall) begin
         o_wdata <= i_data;
      end
   end

   // Read data and drive enable; in DMA the served request/ack path with rd_n low opens the bus.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_data    <= '0;
         o_data_oe <= 1'b0;
      end else begin
         o_data    <= (pio_d || dma_d) ? i_dev_rdata : i_host_rdata;
         o_data_oe <= !rd_n && ((pio_h || pio_d) && !phase || dma_h || dma_d);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_host_dma_done <= 1'b0;
         o_dev_dma_done  <= 1'b0;
      end else begin
         o_host_dma_done <= i_host_end_of_transfer;
         o_dev_dma_done  <= i_dev_end_of_transfer;
      end
   end

   dcb_host_map #(
      .AW (AW)
   ) u_map (
      .i_clk          (i_clk),
      .i_rst          (i_rst),
      .i_iso_size     (i_iso_buffer_size_setting),
      .i_int_size     (i_interrupt_buffer_size_setting),
      .i_async_size   (i_async_buffer_size_setting),
      .i_int_blk      (i_interrupt_block_size_setting),
      .i_async_blk    (i_async_block_size_setting),
      .i_iso_hdr      (i_iso_hdr_addr),
      .i_iso_total    (i_iso_total_size),
      .o_iso_b_start  (o_iso_b_start),
      .o_int_start    (o_int_start),
      .o_async_start  (o_async_start),
      .o_unused_start (o_unused_start),
      .o_int_blocks   (o_int_blocks),
      .o_async_blocks (o_async_blocks),
      .o_iso_next_hdr (o_iso_next_hdr)
   );

   // Flags a map reaching past the host memory end.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_host_map_overflow <= 1'b0;
      end else begin
         o_host_map_overflow <= ({1'b0, o_unused_start} > (AW+1)'(`DCB_HOST_MEM_BYTES));
      end
   end

   // Endpoint configuration; allocation waits until all sixteen are written.
   logic [NEP-1:0] ep_seen_q;
   logic [11:0]    ep_bytes_q [NEP];
   logic [15:0]    ep_total;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ep_seen_q <= '0;
         for (int k = 0; k < NEP; k++) ep_bytes_q[k] <= '0;
      end else if (i_ep_cfg_wr) begin
         ep_seen_q[i_ep_cfg_index]  <= 1'b1;
         ep_bytes_q[i_ep_cfg_index] <= i_ep_cfg_dbl ? {1'b0, i_ep_cfg_size, 1'b0}
                                                    : {2'b00, i_ep_cfg_size};
      end
   end
   always_comb begin
      ep_total = '0;
      for (int k = 0; k < NEP; k++) ep_total = 16'(ep_total + {4'h0, ep_bytes_q[k]});
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ep_alloc_done <= 1'b0;
         o_ep_cfg_err    <= 1'b0;
      end else begin
         o_ep_alloc_done <= &ep_seen_q && ep_total <= 16'(`DCB_DEV_MEM_BYTES);
         if (i_ep_cfg_wr && i_ep_cfg_index > 4'h1 &&
             (i_ep_cfg_size < 10'(`DCB_EP_MIN_BYTES))) begin
            o_ep_cfg_err <= 1'b1;
         end
      end
   end

   a_cs_wins: assert property (@(posedge i_clk) disable iff (i_rst)
      !cs_n |=> path_q == dcb_pkg::DCB_PIO_HST || path_q == dcb_pkg::DCB_PIO_DEV)
      else $error("dma served under chip select");
   a_sel_route: assert property (@(posedge i_clk) disable iff (i_rst)
      !cs_n && csel |=> path_q == dcb_pkg::DCB_PIO_DEV)
      else $error("select high not device");
   a_ack_no_req: assert property (@(posedge i_clk) disable iff (i_rst)
      cs_n && !req1 && !req2 |=> path_q == dcb_pkg::DCB_IDLE)
      else $error("ack without request served");
   a_all_off: assert property (@(posedge i_clk) disable iff (i_rst)
      cs_n && req1 && req2 && !ack1_n && !ack2_n |=> o_bus_off && !o_data_oe)
      else $error("bus not off");
   a_host_dma: assert property (@(posedge i_clk) disable iff (i_rst)
      cs_n && req1 && !req2 && !ack1_n |=> path_q == dcb_pkg::DCB_DMA_HST)
      else $error("host dma not served");
   a_float_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      path_d == dcb_pkg::DCB_IDLE |=> !o_data_oe)
      else $error("bus driven idle");
   a_cmd_no_read: assert property (@(posedge i_clk) disable iff (i_rst)
      !cs_n && phase |=> !o_data_oe)
      else $error("command port driven");
   a_dma_no_cmd: assert property (@(posedge i_clk) disable iff (i_rst)
      cs_n |=> !o_host_cmd_wr && !o_dev_cmd_wr)
      else $error("register reached by dma");
   c_host_pio: cover property (@(posedge i_clk) o_host_cmd_wr ##[1:40] o_host_data_rd);
   c_dev_dma: cover property (@(posedge i_clk) o_dev_buf_dma);
   c_off: cover property (@(posedge i_clk) o_bus_off);
endmodule : dcb_bus_if

// [dv/dcb_cpu_model.sv]
// Behavioural model of the external processor and its DMA controller on the pins.
// Assumes the bench hands it the design's strobes, read data, data enable and path code.
`timescale 1ns/1ps
module dcb_cpu_model (
   input  wire logic        i_clk,
   input  wire logic [7:0]  i_stb,
   input  wire logic        i_oe,
   input  wire logic [15:0] i_d,
   input  wire logic [2:0]  i_path,
   output logic      [8:0]  o_pins,
   output logic      [15:0] o_wire
);
   // Pin order: cs_n, select, phase, rd_n, wr_n, req1, ack1_n, req2, ack2_n.
   localparam logic [8:0] IDLE = 9'h135;
   logic [15:0] drv_q;
   logic        drv_en;
   logic [15:0] last_q;
   // An undriven bus shows a changing pattern, never a stale value.
   assign o_wire = i_oe ? i_d : (drv_en ? drv_q : ~last_q);
   initial begin
      o_pins = IDLE;
      drv_en = 1'b0;
      drv_q = 16'h0000;
      last_q = 16'h0000;
   end
   always @(posedge i_clk) last_q <= o_wire;
   // Pins are held until a strobe is seen or twelve cycles pass, then one cycle more before sampling and release.
   task automatic xfer(input logic [8:0] pins, input logic [15:0] wd, output logic [7:0] stb,
                       output logic [15:0] rd, output logic oe, output logic [2:0] path);
      int n;
      @(negedge i_clk);
      o_pins = pins;
      drv_q = wd;
      drv_en = !pins[4];
      stb = 8'h00;
      for (n = 0; n < 12 && stb == 8'h00; n++) begin
         @(negedge i_clk);
         stb = i_stb;
      end
      @(posedge i_clk);
      @(negedge i_clk);
      rd = o_wire;
      oe = i_oe;
      path = i_path;
      o_pins = IDLE;
      drv_en = 1'b0;
      repeat (6) @(negedge i_clk);
   endtask : xfer
endmodule : dcb_cpu_model

// [dv/tb_dcb_bus_if.sv]
// Self-checking bench for the bus interface top.
// Assumes the processor model drives all host pins; other inputs come from here.
`timescale 1ns/1ps
module tb_dcb_bus_if;
   logic i_clk, i_rst, i_chip_sel_n, i_controller_select_line, i_phase_select_line;
   logic i_rd_n, i_wr_n, i_host_dma_request, i_host_dma_ack_n, i_dev_dma_request;
   logic i_dev_dma_ack_n, o_data_oe, o_host_cmd_wr, o_host_data_wr, o_host_data_rd;
   logic o_host_buf_dma, o_dev_cmd_wr, o_dev_data_wr, o_dev_data_rd, o_dev_buf_dma;
   logic o_dma_write, i_host_end_of_transfer, i_dev_end_of_transfer, o_host_dma_done;
   logic o_dev_dma_done, o_bus_off, o_host_map_overflow, i_ep_cfg_wr, i_ep_cfg_dbl;
   logic o_ep_alloc_done, o_ep_cfg_err, oe;
   logic [15:0] i_data, o_data, i_host_rdata, i_dev_rdata, o_wdata, rd;
   logic [12:0] i_iso_buffer_size_setting, i_interrupt_buffer_size_setting;
   logic [12:0] i_async_buffer_size_setting, i_interrupt_block_size_setting;
   logic [12:0] i_async_block_size_setting, i_iso_hdr_addr, i_iso_total_size;
   logic [12:0] o_iso_b_start, o_int_start, o_async_start, o_unused_start, o_iso_next_hdr;
   logic [5:0]  o_int_blocks, o_async_blocks;
   logic [2:0]  o_path, path;
   logic [3:0]  i_ep_cfg_index;
   logic [9:0]  i_ep_cfg_size;
   logic [8:0]  pins;
   logic [7:0]  stbv, stb;
   int n_errors = 0, n_checks = 0, cyc = 0, s, n_dmaw = 0;
   // Row: iso, int, async, block, iso header, iso total, int blocks, async blocks, next header.
   logic [12:0] rows [3][9] = '{
      '{13'h400, 13'h400, 13'h400, 13'h040, 13'h000, 13'h005, 13'h00e, 13'h00e, 13'h010},
      '{13'h000, 13'h800, 13'h800, 13'h000, 13'h064, 13'h004, 13'h000, 13'h000, 13'h070},
      '{13'h200, 13'hfa0, 13'h100, 13'h008, 13'h010, 13'h000, 13'h020, 13'h010, 13'h018}};
   assign stbv = {o_host_cmd_wr, o_host_data_wr, o_host_data_rd, o_host_buf_dma,
                  o_dev_cmd_wr, o_dev_data_wr, o_dev_data_rd, o_dev_buf_dma};
   assign {i_chip_sel_n, i_controller_select_line, i_phase_select_line, i_rd_n, i_wr_n,
           i_host_dma_request, i_host_dma_ack_n, i_dev_dma_request, i_dev_dma_ack_n} = pins;
   dcb_bus_if dcb_bus_if_i (.i_clk, .i_rst, .i_chip_sel_n, .i_controller_select_line,
      .i_phase_select_line, .i_rd_n, .i_wr_n, .i_host_dma_request, .i_host_dma_ack_n,
      .i_dev_dma_request, .i_dev_dma_ack_n, .i_data, .o_data, .o_data_oe, .i_host_rdata,
      .i_dev_rdata, .o_wdata, .o_host_cmd_wr, .o_host_data_wr, .o_host_data_rd,
      .o_host_buf_dma, .o_dev_cmd_wr, .o_dev_data_wr, .o_dev_data_rd, .o_dev_buf_dma,
      .o_dma_write, .i_host_end_of_transfer, .i_dev_end_of_transfer, .o_host_dma_done,
      .o_dev_dma_done, .o_bus_off, .o_path, .i_iso_buffer_size_setting,
      .i_interrupt_buffer_size_setting, .i_async_buffer_size_setting,
      .i_interrupt_block_size_setting, .i_async_block_size_setting, .i_iso_hdr_addr,
      .i_iso_total_size, .o_iso_b_start, .o_int_start, .o_async_start, .o_unused_start,
      .o_int_blocks, .o_async_blocks, .o_iso_next_hdr, .o_host_map_overflow, .i_ep_cfg_wr,
      .i_ep_cfg_index, .i_ep_cfg_dbl, .i_ep_cfg_size, .o_ep_alloc_done, .o_ep_cfg_err);
   dcb_cpu_model dcb_cpu_model_i (.i_clk, .i_stb(stbv), .i_oe(o_data_oe), .i_d(o_data),
      .i_path(o_path), .o_pins(pins), .o_wire(i_data));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   // Counts DMA write pulses so a one-cycle strobe can be compared later.
   always @(negedge i_clk) if (o_dma_write === 1'b1) n_dmaw++;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic acc(input logic [8:0] p, input logic [15:0] wd, input logic [7:0] es,
                      input logic [2:0] ep, input logic eo);
      dcb_cpu_model_i.xfer(p, wd, stb, rd, oe, path);
      chk(stb, es);
      chk(path, ep);
      chk(oe, eo);
   endtask : acc
   task automatic ep_wr(input logic [3:0] idx, input logic [9:0] sz, input logic dbl);
      @(negedge i_clk);
      {i_ep_cfg_wr, i_ep_cfg_index, i_ep_cfg_size, i_ep_cfg_dbl} = {1'b1, idx, sz, dbl};
      @(negedge i_clk);
      i_ep_cfg_wr = 1'b0;
   endtask : ep_wr
   initial begin
      {i_rst, i_host_end_of_transfer, i_dev_end_of_transfer, i_ep_cfg_wr} = 4'h8;
      {i_ep_cfg_index, i_ep_cfg_size, i_ep_cfg_dbl} = 15'h0000;
      {i_iso_buffer_size_setting, i_interrupt_buffer_size_setting} = 26'h0;
      {i_async_buffer_size_setting, i_interrupt_block_size_setting} = 26'h0;
      {i_async_block_size_setting, i_iso_hdr_addr, i_iso_total_size} = 39'h0;
      i_host_rdata = 16'h1234;
      i_dev_rdata = 16'habcd;
      repeat (5) @(negedge i_clk);
      chk({o_path, o_bus_off, o_ep_alloc_done, o_ep_cfg_err, o_data_oe, stbv}, 16'h0000);
      i_rst = 1'b0;
      // Software keeps block sizes in multiples of four; the last row overfills on purpose.
      for (s = 0; s < 3; s++) begin
         i_iso_buffer_size_setting = rows[s][0];
         i_interrupt_buffer_size_setting = rows[s][1];
         i_async_buffer_size_setting = rows[s][2];
         i_interrupt_block_size_setting = rows[s][3];
         i_async_block_size_setting = rows[s][3];
         i_iso_hdr_addr = rows[s][4];
         i_iso_total_size = rows[s][5];
         repeat (3) @(negedge i_clk);
         chk(o_iso_b_start, rows[s][0]);
         chk(o_int_start, 2 * rows[s][0]);
         chk(o_async_start, 2 * rows[s][0] + rows[s][1]);
         chk(o_unused_start, 2 * rows[s][0] + rows[s][1] + rows[s][2]);
         chk(o_host_map_overflow, (2 * rows[s][0] + rows[s][1] + rows[s][2]) > 4096);
         chk(o_int_blocks, rows[s][6]);
         chk(o_async_blocks, rows[s][7]);
         chk(o_iso_next_hdr, rows[s][8]);
      end
      acc(9'h065, 16'h0081, 8'h80, 3'h1, 1'b0);
      chk(o_wdata, 16'h0081);
      acc(9'h029, 16'h5a5a, 8'h40, 3'h1, 1'b0);
      chk(o_wdata, 16'h5a5a);
      acc(9'h019, 16'h0000, 8'h20, 3'h1, 1'b1);
      chk(rd, 16'h1234);
      acc(9'h0e5, 16'h0042, 8'h08, 3'h2, 1'b0);
      acc(9'h0a5, 16'h3c3c, 8'h04, 3'h2, 1'b0);
      chk(o_wdata, 16'h3c3c);
      acc(9'h095, 16'h0000, 8'h02, 3'h2, 1'b1);
      chk(rd, 16'habcd);
      acc(9'h199, 16'h0000, 8'h10, 3'h3, 1'b1);
      chk(16'(n_dmaw), 16'h0000);
      acc(9'h126, 16'h7e81, 8'h01, 3'h4, 1'b0);
      chk(o_wdata, 16'h7e81);
      chk(16'(n_dmaw), 16'h0001);
      acc(9'h111, 16'h0000, 8'h00, 3'h0, 1'b0);
      acc(9'h11b, 16'h0000, 8'h00, 3'h0, 1'b0);
      acc(9'h11a, 16'h0000, 8'h00, 3'h5, 1'b0);
      @(negedge i_clk);
      i_host_end_of_transfer = 1'b1;
      @(negedge i_clk);
      chk({o_host_dma_done, o_dev_dma_done}, 16'h0002);
      {i_host_end_of_transfer, i_dev_end_of_transfer} = 2'b01;
      @(negedge i_clk);
      chk({o_host_dma_done, o_dev_dma_done}, 16'h0001);
      i_dev_end_of_transfer = 1'b0;
      for (s = 0; s < 15; s++) ep_wr(s, (s < 2) ? 10'h040 : 10'h010, 1'b0);
      repeat (2) @(negedge i_clk);
      chk(o_ep_alloc_done, 1'b0);
      ep_wr(4'hf, 10'h010, 1'b0);
      repeat (2) @(negedge i_clk);
      chk({o_ep_alloc_done, o_ep_cfg_err}, 16'h0002);
      ep_wr(4'h3, 10'h3ff, 1'b1);
      ep_wr(4'h4, 10'h3ff, 1'b0);
      repeat (2) @(negedge i_clk);
      chk(o_ep_alloc_done, 1'b0);
      ep_wr(4'h2, 10'h008, 1'b0);
      repeat (2) @(negedge i_clk);
      chk(o_ep_cfg_err, 1'b1);
      i_rst = 1'b1;
      @(negedge i_clk);
      i_rst = 1'b0;
      chk({o_ep_cfg_err, o_ep_alloc_done, o_path}, 16'h0000);
      report_and_stop();
   end
endmodule : tb_dcb_bus_if
